// ---- src/mmbd_regs.svh ----
// Constants of the memory map and bank decode block: vectors, page limits,
// field positions and reset values. Included by bare name; definitions only.
`ifndef MMBD_REGS_SVH
`define MMBD_REGS_SVH

`define MMBD_PC_WIDTH        11
`define MMBD_STACK_DEPTH     8
`define MMBD_PC_RESET        11'h000
`define MMBD_VEC_SOFTWARE    11'h001
`define MMBD_VEC_HARDWARE    11'h008
`define MMBD_ROLL_CODE_FIRST 11'h00E
`define MMBD_ROLL_CODE_LAST  11'h00F
`define MMBD_RESERVED_FIRST  11'h7FE
`define MMBD_SHORT_SPAN_W    8

`define MMBD_SFR_LAST        7'h1F
`define MMBD_RAM_FIRST       7'h20
`define MMBD_BANK1_RAM_LAST  7'h3F
`define MMBD_SFR_INDIRECT    5'h00
`define MMBD_SFR_STATUS      5'h03
`define MMBD_SFR_POINTER     5'h04
`define MMBD_BANK_FIELD_HI   7
`define MMBD_BANK_FIELD_LO   6
`define MMBD_BANK_RESET      2'h0
`define MMBD_POINTER_RESET   8'h00

`endif

// ---- src/mmbd_pkg.sv ----
// Types shared by the memory map and bank decode block.
// Assumes the sequencer drives one program counter operation and at most one
// data access per clock.
package mmbd_pkg;

    typedef enum logic [3:0] {
        MMBD_PC_HOLD,
        MMBD_PC_STEP,
        MMBD_PC_SHORT_JUMP,
        MMBD_PC_FAR_JUMP,
        MMBD_PC_SHORT_CALL,
        MMBD_PC_FAR_CALL,
        MMBD_PC_PLAIN_RETURN,
        MMBD_PC_RETURN_WITH_LITERAL,
        MMBD_PC_RETURN_FROM_INTERRUPT,
        MMBD_PC_SW_INT,
        MMBD_PC_HW_INT
    } mmbd_pc_op_t;

    typedef enum logic [2:0] {
        MMBD_ACC_NONE,
        MMBD_ACC_R_READ,
        MMBD_ACC_R_WRITE,
        MMBD_ACC_IO_PAGE_READ,
        MMBD_ACC_IO_PAGE_WRITE,
        MMBD_ACC_SPECIAL_PAGE_READ,
        MMBD_ACC_SPECIAL_PAGE_WRITE
    } mmbd_acc_op_t;

    typedef enum logic [1:0] {
        MMBD_PAGE_R,
        MMBD_PAGE_IO,
        MMBD_PAGE_SPECIAL
    } mmbd_page_t;

    typedef enum logic [1:0] {
        MMBD_SRC_RAM,
        MMBD_SRC_EXT,
        MMBD_SRC_STATUS,
        MMBD_SRC_HELD
    } mmbd_src_t;

    typedef struct packed {
        mmbd_acc_op_t op;
        logic [6:0]   addr;
        logic [7:0]   wdata;
    } mmbd_access_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        mmbd_page_t page;
        logic [4:0] addr;
        logic [7:0] wdata;
    } mmbd_sfr_bus_t;

    typedef struct packed {
        logic       is_sfr;
        logic [4:0] sfr_addr;
        logic [6:0] ram_idx;
    } mmbd_target_t;

endpackage : mmbd_pkg

// ---- src/mmbd_ram.sv ----
// General-purpose RAM of the data memory: one synchronous write port and one
// read port whose data come out of a register one clock after the address.
// Assumes the caller never reads and writes different words in one clock.
`timescale 1ns/10ps
module mmbd_ram #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rstn,
    // Access
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rdata_reg;

    generate
        if (AW < 1 || DW < 1) begin : g_bad
            $error("mmbd_ram: widths must be positive");
        end
    endgenerate

    // The array has no reset; its contents are undefined after power-up.
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= mem[addr];
        end
    end

    assign rdata = rdata_reg;

endmodule : mmbd_ram

// ---- src/mmbd_top.sv ----
// Program counter, return stack and data memory decode of the 8-bit core.
// Assumes the sequencer drives PC_OP and ACCESS synchronous to CLK and that
// peripheral registers answer SFR_RDATA combinationally from SFR_BUS.
`timescale 1ns/10ps
`include "mmbd_regs.svh"
module mmbd_top #(
    parameter int PC_W  = `MMBD_PC_WIDTH,
    parameter int DEPTH = `MMBD_STACK_DEPTH
) (
    // Clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RSTN,
    // Program flow from the sequencer
    input  wire mmbd_pkg::mmbd_pc_op_t  PC_OP,
    input  wire logic [PC_W-1:0]        TARGET,
    output logic      [PC_W-1:0]        PC,
    // Data access from the datapath
    input  wire mmbd_pkg::mmbd_access_t ACCESS,
    output logic      [7:0]             RD_DATA,
    output logic                        RD_VALID,
    // Peripheral register bus
    output mmbd_pkg::mmbd_sfr_bus_t     SFR_BUS,
    input  wire logic [7:0]             SFR_RDATA,
    // Decode state for the datapath
    output logic      [1:0]             BANK_SELECT_FIELD,
    output logic      [7:0]             FILE_POINTER
);

    localparam int SP_W    = $clog2(DEPTH);
    localparam int SHORT_W = `MMBD_SHORT_SPAN_W;

    // Refuse shapes that the stack pointer or the short jump split cannot serve.
    generate
        if (PC_W <= SHORT_W || PC_W > 16) begin : g_bad_pc
            $error("mmbd_top: PC_W must exceed the short jump span and be at most 16");
        end
        if (DEPTH < 2 || (1 << SP_W) != DEPTH) begin : g_bad_depth
            $error("mmbd_top: DEPTH must be a power of two of at least 2");
        end
    endgenerate

    typedef struct packed {
        // Program flow.
        logic [PC_W-1:0]                pc;
        logic [SP_W-1:0]                sp;
        logic [DEPTH-1:0][PC_W-1:0]     stack;

        // Data decode.
        logic [1:0]                     bank;
        logic [7:0]                     pointer;

        // Read pipeline.
        logic                           st1_valid;
        mmbd_pkg::mmbd_src_t            st1_src;
        logic [7:0]                     st1_held;
        logic [7:0]                     rd_data;
        logic                           rd_valid;

        // Peripheral strobes.
        mmbd_pkg::mmbd_sfr_bus_t        sfr;
    } mmbd_state_t;

    mmbd_state_t            state_reg;
    mmbd_state_t            state_next;
    logic                   ram_we;
    logic [6:0]             ram_addr;
    logic [7:0]             ram_rdata;
    mmbd_pkg::mmbd_target_t direct_tgt;
    mmbd_pkg::mmbd_target_t indirect_tgt;

    // Folds a bank and a location onto the physical map. Only an odd bank
    // below 0x40 reaches the bank 1 RAM; every other RAM address lands on
    // bank 0, so the RAM index is the location itself or its low five bits.
    function automatic mmbd_pkg::mmbd_target_t decode_loc(
        input logic [1:0] bank,
        input logic [6:0] loc
    );
        mmbd_pkg::mmbd_target_t t;
        t.is_sfr   = (loc <= `MMBD_SFR_LAST);
        t.sfr_addr = loc[4:0];
        if (bank[0] && loc <= `MMBD_BANK1_RAM_LAST) begin
            t.ram_idx = 7'(loc - `MMBD_RAM_FIRST);
        end else begin
            t.ram_idx = loc;
        end
        return t;
    endfunction : decode_loc

    assign direct_tgt   = decode_loc(state_reg.bank, ACCESS.addr);
    assign indirect_tgt = decode_loc(state_reg.bank, state_reg.pointer[6:0]);

    always_comb begin
        mmbd_pkg::mmbd_target_t tgt;
        logic                   is_rd;
        logic                   is_wr;
        logic                   indirect;
        state_next = state_reg;
        tgt        = direct_tgt;
        is_rd      = 1'b0;
        is_wr      = 1'b0;
        indirect   = 1'b0;
        ram_we     = 1'b0;
        ram_addr   = direct_tgt.ram_idx;

        // Program flow.
        unique case (PC_OP)
            mmbd_pkg::MMBD_PC_HOLD: begin
                state_next.pc = state_reg.pc;
            end

            mmbd_pkg::MMBD_PC_STEP: begin
                state_next.pc = state_reg.pc + 1'b1;
            end

            // A short transfer keeps the upper PC bits and replaces only the low byte.
            mmbd_pkg::MMBD_PC_SHORT_JUMP: begin
                state_next.pc = {state_reg.pc[PC_W-1:SHORT_W], TARGET[SHORT_W-1:0]};
            end

            mmbd_pkg::MMBD_PC_FAR_JUMP: begin
                state_next.pc = TARGET;
            end

            mmbd_pkg::MMBD_PC_SHORT_CALL: begin
                state_next.stack[state_reg.sp] = state_reg.pc + 1'b1;
                state_next.sp = state_reg.sp + 1'b1;
                state_next.pc = {state_reg.pc[PC_W-1:SHORT_W], TARGET[SHORT_W-1:0]};
            end

            mmbd_pkg::MMBD_PC_FAR_CALL: begin
                state_next.stack[state_reg.sp] = state_reg.pc + 1'b1;
                state_next.sp = state_reg.sp + 1'b1;
                state_next.pc = TARGET;
            end

            // The three returns pop alike; what the literal or the interrupt enable
            // does afterwards is left to the datapath.
            mmbd_pkg::MMBD_PC_PLAIN_RETURN,
            mmbd_pkg::MMBD_PC_RETURN_WITH_LITERAL,
            mmbd_pkg::MMBD_PC_RETURN_FROM_INTERRUPT: begin
                state_next.sp = state_reg.sp - 1'b1;
                state_next.pc = state_reg.stack[SP_W'(state_reg.sp - 1'b1)];
            end

            // An interrupt is taken before the instruction at PC runs, so
            // that instruction is the one to resume at.
            mmbd_pkg::MMBD_PC_SW_INT: begin
                state_next.stack[state_reg.sp] = state_reg.pc;
                state_next.sp = state_reg.sp + 1'b1;
                state_next.pc = PC_W'(`MMBD_VEC_SOFTWARE);
            end

            mmbd_pkg::MMBD_PC_HW_INT: begin
                state_next.stack[state_reg.sp] = state_reg.pc;
                state_next.sp = state_reg.sp + 1'b1;
                state_next.pc = PC_W'(`MMBD_VEC_HARDWARE);
            end

            default: begin
                state_next.pc = state_reg.pc;
            end
        endcase
        // The stack wraps silently: a ninth push overwrites the oldest entry and no
        // flag is raised, so nesting deeper than the stack is the program's fault.
        // Words 0x00E and 0x00F get no special treatment, so code may use them.

        // Second stage: the read answer.
        // The RAM answers from its own output register, so every source is taken
        // at the same second edge and RD_VALID follows each read by two clocks.
        state_next.rd_valid = state_reg.st1_valid;
        unique case (state_reg.st1_src)
            mmbd_pkg::MMBD_SRC_RAM: begin
                state_next.rd_data = ram_rdata;
            end

            mmbd_pkg::MMBD_SRC_EXT: begin
                state_next.rd_data = SFR_RDATA;
            end

            mmbd_pkg::MMBD_SRC_STATUS: begin
                state_next.rd_data = {state_reg.bank, SFR_RDATA[5:0]};
            end

            mmbd_pkg::MMBD_SRC_HELD: begin
                state_next.rd_data = state_reg.st1_held;
            end

            default: begin
                state_next.rd_data = state_reg.st1_held;
            end
        endcase
        if (!state_reg.st1_valid) begin
            state_next.rd_data = state_reg.rd_data;
        end

        // First stage: decode the new access.
        state_next.st1_valid = 1'b0;
        state_next.st1_src   = mmbd_pkg::MMBD_SRC_HELD;
        state_next.st1_held  = 8'h00;
        state_next.sfr       = '0;
        unique case (ACCESS.op)
            mmbd_pkg::MMBD_ACC_R_READ,
            mmbd_pkg::MMBD_ACC_R_WRITE: begin
                is_rd    = (ACCESS.op == mmbd_pkg::MMBD_ACC_R_READ);
                is_wr    = !is_rd;
                indirect = direct_tgt.is_sfr && direct_tgt.sfr_addr == `MMBD_SFR_INDIRECT;
                tgt      = indirect ? indirect_tgt : direct_tgt;
                state_next.st1_valid = is_rd;

                if (indirect && tgt.is_sfr && tgt.sfr_addr == `MMBD_SFR_INDIRECT) begin
                    // A pointer aimed at the indirect port itself reads zero
                    // and drops writes, instead of looping.
                    state_next.st1_src = mmbd_pkg::MMBD_SRC_HELD;
                end else if (tgt.is_sfr) begin
                    unique case (tgt.sfr_addr)
                        // The pointer is kept here because the indirect decode needs it
                        // in the same clock as the access; the peripheral bus never sees it.
                        `MMBD_SFR_POINTER: begin
                            state_next.st1_src  = mmbd_pkg::MMBD_SRC_HELD;
                            state_next.st1_held = state_reg.pointer;
                            if (is_wr) begin
                                state_next.pointer = ACCESS.wdata;
                            end
                        end

                        `MMBD_SFR_STATUS: begin
                            // The rest of the status byte lives in a peripheral register on SFR_BUS;
                            // only the bank field is kept here.
                            state_next.st1_src = mmbd_pkg::MMBD_SRC_STATUS;
                            state_next.sfr.rd  = is_rd;
                            state_next.sfr.wr  = is_wr;
                            state_next.sfr.page  = mmbd_pkg::MMBD_PAGE_R;
                            state_next.sfr.addr  = tgt.sfr_addr;
                            state_next.sfr.wdata = ACCESS.wdata;
                            if (is_wr) begin
                                state_next.bank =
                                    ACCESS.wdata[`MMBD_BANK_FIELD_HI:`MMBD_BANK_FIELD_LO];
                            end
                        end

                        default: begin
                            state_next.st1_src   = mmbd_pkg::MMBD_SRC_EXT;
                            state_next.sfr.rd    = is_rd;
                            state_next.sfr.wr    = is_wr;
                            state_next.sfr.page  = mmbd_pkg::MMBD_PAGE_R;
                            state_next.sfr.addr  = tgt.sfr_addr;
                            state_next.sfr.wdata = ACCESS.wdata;
                        end
                    endcase
                end else begin
                    state_next.st1_src = mmbd_pkg::MMBD_SRC_RAM;
                    ram_we   = is_wr;
                    ram_addr = tgt.ram_idx;
                end
            end

            // The I/O and special pages take the opcode address as it stands; the
            // bank field plays no part in these accesses.
            mmbd_pkg::MMBD_ACC_IO_PAGE_READ,
            mmbd_pkg::MMBD_ACC_IO_PAGE_WRITE: begin
                is_rd = (ACCESS.op == mmbd_pkg::MMBD_ACC_IO_PAGE_READ);
                state_next.st1_valid = is_rd;
                state_next.st1_src   = mmbd_pkg::MMBD_SRC_EXT;
                state_next.sfr.rd    = is_rd;
                state_next.sfr.wr    = !is_rd;
                state_next.sfr.page  = mmbd_pkg::MMBD_PAGE_IO;
                state_next.sfr.addr  = ACCESS.addr[4:0];
                state_next.sfr.wdata = ACCESS.wdata;
            end

            mmbd_pkg::MMBD_ACC_SPECIAL_PAGE_READ,
            mmbd_pkg::MMBD_ACC_SPECIAL_PAGE_WRITE: begin
                is_rd = (ACCESS.op == mmbd_pkg::MMBD_ACC_SPECIAL_PAGE_READ);
                state_next.st1_valid = is_rd;
                state_next.st1_src   = mmbd_pkg::MMBD_SRC_EXT;
                state_next.sfr.rd    = is_rd;
                state_next.sfr.wr    = !is_rd;
                state_next.sfr.page  = mmbd_pkg::MMBD_PAGE_SPECIAL;
                state_next.sfr.addr  = ACCESS.addr[4:0];
                state_next.sfr.wdata = ACCESS.wdata;
            end

            default: begin
                state_next.st1_valid = 1'b0;
            end
        endcase
    end

    // The whole state register is cleared; the RAM array keeps whatever it held.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_reg         <= '0;
            state_reg.pc      <= PC_W'(`MMBD_PC_RESET);
            state_reg.bank    <= `MMBD_BANK_RESET;
            state_reg.pointer <= `MMBD_POINTER_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Both RAM banks share one 128-word array; the alias decode above folds every
    // bank address onto it, so no word is ever stored twice.
    mmbd_ram #(
        .AW (7),
        .DW (8)
    ) u_ram (
        .clk   (CLK),
        .rstn  (RSTN),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (ACCESS.wdata),
        .rdata (ram_rdata)
    );

    // Every output comes straight from the state register.
    assign PC                = state_reg.pc;
    assign RD_DATA           = state_reg.rd_data;
    assign RD_VALID          = state_reg.rd_valid;
    assign SFR_BUS           = state_reg.sfr;
    assign BANK_SELECT_FIELD = state_reg.bank;
    assign FILE_POINTER      = state_reg.pointer;

endmodule : mmbd_top

// ---- sim/mmbd_periph.sv ----
// Model of the peripheral registers that answer the register bus of the decode block.
// Assumes one strobe per clock; read data is answered combinationally.
`timescale 1ns/10ps
module mmbd_periph (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // Register bus
    input  wire mmbd_pkg::mmbd_sfr_bus_t sfr_bus,
    output logic [7:0]                   sfr_rdata
);
    logic [7:0] store_reg [0:95];
    logic [7:0] last_reg;
    logic [6:0] idx;

    assign idx = {sfr_bus.page, sfr_bus.addr};
    // Unselected cycles show the inverse of the last answer, so a late sample cannot match by luck.
    assign sfr_rdata = sfr_bus.rd ? store_reg[idx] : ~last_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_reg <= 8'h00;
            for (int i = 0; i < 96; i++) begin
                store_reg[i] <= 8'h00;
            end
        end else begin
            if (sfr_bus.wr) begin
                store_reg[idx] <= sfr_bus.wdata;
            end
            if (sfr_bus.rd) begin
                last_reg <= store_reg[idx];
            end
        end
    end
endmodule : mmbd_periph

// ---- sim/mmbd_monitor.sv ----
// Checker of the decode block: program flow, read timing and register bus decode.
// Assumes it is bound to mmbd_top and sees only its ports.
`timescale 1ns/10ps
module mmbd_monitor #(
    parameter int PC_W  = 11,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic                    CLK,
    input wire logic                    RSTN,
    // Program flow
    input wire mmbd_pkg::mmbd_pc_op_t   PC_OP,
    input wire logic [PC_W-1:0]         TARGET,
    input wire logic [PC_W-1:0]         PC,
    // Data access
    input wire mmbd_pkg::mmbd_access_t  ACCESS,
    input wire logic [7:0]              RD_DATA,
    input wire logic                    RD_VALID,
    input wire mmbd_pkg::mmbd_sfr_bus_t SFR_BUS,
    input wire logic [7:0]              SFR_RDATA,
    // Decode state
    input wire logic [1:0]              BANK_SELECT_FIELD,
    input wire logic [7:0]              FILE_POINTER
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    logic is_rd;
    assign is_rd = ACCESS.op inside {mmbd_pkg::MMBD_ACC_R_READ, mmbd_pkg::MMBD_ACC_IO_PAGE_READ,
                                     mmbd_pkg::MMBD_ACC_SPECIAL_PAGE_READ};

    a_reset_vector: assert property ($rose(RSTN) |-> PC == 11'h000)
        else $error("pc not at reset vector");
    a_soft_vector: assert property (PC_OP == mmbd_pkg::MMBD_PC_SW_INT |=> PC == 11'h001)
        else $error("software vector wrong");
    a_hard_vector: assert property (PC_OP == mmbd_pkg::MMBD_PC_HW_INT |=> PC == 11'h008)
        else $error("hardware vector wrong");
    a_short_span: assert property (PC_OP == mmbd_pkg::MMBD_PC_SHORT_JUMP
        |=> PC == {$past(PC[PC_W-1:8]), $past(TARGET[7:0])}) else $error("short jump wrong");
    a_far_reach: assert property (PC_OP inside {mmbd_pkg::MMBD_PC_FAR_JUMP, mmbd_pkg::MMBD_PC_FAR_CALL}
        |=> PC == $past(TARGET)) else $error("far target wrong");
    a_call_return: assert property ((PC_OP == mmbd_pkg::MMBD_PC_FAR_CALL) ##1
        (PC_OP == mmbd_pkg::MMBD_PC_PLAIN_RETURN) |=> PC == $past(PC, 2) + 11'h001) else $error("call return wrong");
    a_int_return: assert property ((PC_OP == mmbd_pkg::MMBD_PC_HW_INT) ##1
        (PC_OP == mmbd_pkg::MMBD_PC_RETURN_FROM_INTERRUPT) |=> PC == $past(PC, 2)) else $error("int return wrong");
    a_read_latency: assert property (is_rd |-> ##2 RD_VALID)
        else $error("read answer late");
    a_valid_cause: assert property (RD_VALID |-> $past(is_rd, 2))
        else $error("answer without read");
    a_periph_answer: assert property (SFR_BUS.rd |=> RD_VALID && RD_DATA[5:0] == $past(SFR_RDATA[5:0]))
        else $error("peripheral data lost");
    a_bank_write: assert property (ACCESS.op == mmbd_pkg::MMBD_ACC_R_WRITE && ACCESS.addr == 7'h03
        |=> BANK_SELECT_FIELD == $past(ACCESS.wdata[7:6])) else $error("bank field not written");
    a_page_write: assert property (ACCESS.op == mmbd_pkg::MMBD_ACC_IO_PAGE_WRITE
        |=> SFR_BUS.wr && SFR_BUS.page == mmbd_pkg::MMBD_PAGE_IO && SFR_BUS.addr == $past(ACCESS.addr[4:0]))
        else $error("io page write wrong");
    a_sfr_mirror: assert property (ACCESS.op == mmbd_pkg::MMBD_ACC_R_WRITE && ACCESS.addr == 7'h05
        |=> SFR_BUS.wr && SFR_BUS.page == mmbd_pkg::MMBD_PAGE_R && SFR_BUS.addr == 5'h05) else $error("mirror wrong");

    c_call: cover property ((PC_OP == mmbd_pkg::MMBD_PC_FAR_CALL) ##1 (PC_OP == mmbd_pkg::MMBD_PC_PLAIN_RETURN));
    c_periph: cover property (SFR_BUS.rd ##1 RD_VALID);
    c_special: cover property (SFR_BUS.wr && SFR_BUS.page == mmbd_pkg::MMBD_PAGE_SPECIAL);
endmodule : mmbd_monitor

bind mmbd_top mmbd_monitor #(.PC_W(PC_W), .DEPTH(DEPTH)) i_mmbd_monitor (.CLK(CLK), .RSTN(RSTN),
    .PC_OP(PC_OP), .TARGET(TARGET), .PC(PC), .ACCESS(ACCESS), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
    .SFR_BUS(SFR_BUS), .SFR_RDATA(SFR_RDATA), .BANK_SELECT_FIELD(BANK_SELECT_FIELD), .FILE_POINTER(FILE_POINTER));

// ---- sim/mmbd_test.sv ----
// Self-checking bench of the decode block with a peripheral register model.
// Assumes the checker is bound to the design.
`timescale 1ns/10ps
module mmbd_test;
    logic                    clk    = 1'b0;
    logic                    rstn   = 1'b0;
    mmbd_pkg::mmbd_pc_op_t   pc_op  = mmbd_pkg::MMBD_PC_HOLD;
    logic [10:0]             target = 11'h000;
    logic [10:0]             pc;
    mmbd_pkg::mmbd_access_t  access = '0;
    logic [7:0]              rd_data;
    logic                    rd_valid;
    mmbd_pkg::mmbd_sfr_bus_t sfr_bus;
    logic [7:0]              sfr_rdata;
    logic [1:0]              bank;
    logic [7:0]              fptr;
    int                      err_count = 0;
    int                      n_checks = 0;

    always #5 clk = ~clk;

    mmbd_top i_mmbd_top (.CLK(clk), .RSTN(rstn), .PC_OP(pc_op), .TARGET(target), .PC(pc), .ACCESS(access),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .SFR_BUS(sfr_bus), .SFR_RDATA(sfr_rdata),
        .BANK_SELECT_FIELD(bank), .FILE_POINTER(fptr));
    mmbd_periph i_mmbd_periph (.clk(clk), .rstn(rstn), .sfr_bus(sfr_bus), .sfr_rdata(sfr_rdata));

    task automatic chk(input string name, input logic [10:0] seen, input logic [10:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic flow(input mmbd_pkg::mmbd_pc_op_t op, input logic [10:0] t);
        @(posedge clk);
        pc_op <= op;
        target <= t;
    endtask : flow

    // Lets the pending operation land, then compares the program counter.
    task automatic pc_is(input logic [10:0] exp);
        @(posedge clk);
        pc_op <= mmbd_pkg::MMBD_PC_HOLD;
        #1;
        chk("pc", pc, exp);
    endtask : pc_is

    // The access stays up until the next call replaces it, so back-to-back accesses are each taken once.
    task automatic put(input mmbd_pkg::mmbd_acc_op_t op, input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        access <= '{op, a, d};
    endtask : put

    task automatic sel(input logic [1:0] b);
        put(mmbd_pkg::MMBD_ACC_R_WRITE, 7'h03, {b, 6'h15});
    endtask : sel

    task automatic get(input mmbd_pkg::mmbd_acc_op_t op, input logic [6:0] a, input logic [7:0] exp);
        int n;
        put(op, a, 8'h00);
        @(posedge clk);
        access <= '0;
        #1;
        n = 0;
        while (rd_valid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        // A value seen n edges after the taking edge is sampled at the edge after that.
        chk("read latency", 11'(n + 1), 11'h002);
        if (n == 4) begin
            end_of_test();
        end
        chk("read data", {3'h0, rd_data}, {3'h0, exp});
    endtask : get

    task automatic t_flow;
        flow(mmbd_pkg::MMBD_PC_FAR_JUMP, 11'h3A5);
        pc_is(11'h3A5);
        flow(mmbd_pkg::MMBD_PC_SHORT_JUMP, 11'h712);
        pc_is(11'h312);
        flow(mmbd_pkg::MMBD_PC_SW_INT, 11'h000);
        pc_is(11'h001);
        flow(mmbd_pkg::MMBD_PC_HW_INT, 11'h000);
        pc_is(11'h008);
        flow(mmbd_pkg::MMBD_PC_FAR_JUMP, 11'h7FD);
        pc_is(11'h7FD);
        flow(mmbd_pkg::MMBD_PC_FAR_JUMP, 11'h00E);
        flow(mmbd_pkg::MMBD_PC_STEP, 11'h000);
        pc_is(11'h00F);
    endtask : t_flow

    task automatic t_stack;
        flow(mmbd_pkg::MMBD_PC_FAR_JUMP, 11'h010);
        flow(mmbd_pkg::MMBD_PC_FAR_CALL, 11'h300);
        flow(mmbd_pkg::MMBD_PC_SHORT_CALL, 11'h045);
        flow(mmbd_pkg::MMBD_PC_PLAIN_RETURN, 11'h000);
        pc_is(11'h301);
        flow(mmbd_pkg::MMBD_PC_RETURN_WITH_LITERAL, 11'h000);
        pc_is(11'h011);
        flow(mmbd_pkg::MMBD_PC_FAR_JUMP, 11'h123);
        flow(mmbd_pkg::MMBD_PC_HW_INT, 11'h000);
        flow(mmbd_pkg::MMBD_PC_RETURN_FROM_INTERRUPT, 11'h000);
        pc_is(11'h123);
        flow(mmbd_pkg::MMBD_PC_FAR_CALL, 11'h500);
        flow(mmbd_pkg::MMBD_PC_PLAIN_RETURN, 11'h000);
        pc_is(11'h124);
    endtask : t_stack

    task automatic t_banks;
        sel(2'h0);
        put(mmbd_pkg::MMBD_ACC_R_WRITE, 7'h25, 8'h11);
        sel(2'h1);
        put(mmbd_pkg::MMBD_ACC_R_WRITE, 7'h25, 8'h22);
        sel(2'h3);
        put(mmbd_pkg::MMBD_ACC_R_WRITE, 7'h55, 8'h33);
        get(mmbd_pkg::MMBD_ACC_R_READ, 7'h03, 8'hD5);
        chk("bank", {9'h000, bank}, 11'h003);
        get(mmbd_pkg::MMBD_ACC_R_READ, 7'h25, 8'h22);
        sel(2'h2);
        get(mmbd_pkg::MMBD_ACC_R_READ, 7'h25, 8'h11);
        sel(2'h0);
        get(mmbd_pkg::MMBD_ACC_R_READ, 7'h55, 8'h33);
    endtask : t_banks

    task automatic t_indirect;
        sel(2'h1);
        put(mmbd_pkg::MMBD_ACC_R_WRITE, 7'h04, 8'hAA);
        put(mmbd_pkg::MMBD_ACC_R_WRITE, 7'h00, 8'h5C);
        sel(2'h3);
        #1;
        chk("pointer", {3'h0, fptr}, 11'h0AA);
        get(mmbd_pkg::MMBD_ACC_R_READ, 7'h2A, 8'h5C);
        get(mmbd_pkg::MMBD_ACC_R_READ, 7'h00, 8'h5C);
    endtask : t_indirect

    task automatic t_pages;
        put(mmbd_pkg::MMBD_ACC_IO_PAGE_WRITE, 7'h05, 8'h77);
        put(mmbd_pkg::MMBD_ACC_SPECIAL_PAGE_WRITE, 7'h05, 8'h88);
        put(mmbd_pkg::MMBD_ACC_R_WRITE, 7'h05, 8'h99);
        sel(2'h2);
        get(mmbd_pkg::MMBD_ACC_IO_PAGE_READ, 7'h05, 8'h77);
        get(mmbd_pkg::MMBD_ACC_SPECIAL_PAGE_READ, 7'h05, 8'h88);
        get(mmbd_pkg::MMBD_ACC_R_READ, 7'h05, 8'h99);
    endtask : t_pages

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("reset pc", pc, 11'h000);
        chk("reset pointer", {3'h0, fptr}, 11'h000);
        t_flow();
        t_stack();
        t_banks();
        t_indirect();
        t_pages();
        end_of_test();
    end
endmodule : mmbd_test
